// [watchdog_and_clock_monitor.sv]
// Processor supervisor: service-sequence watchdog, slow-clock monitor,
// stop and wait power states, processor reset with cause vector.
// Assumes an AHB-Lite master on hclk and a slow reference on clkmon_ref.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "watchdog_defines.svh"
module watchdog_and_clock_monitor
  import watchdog_pkg::*;
#(
  parameter logic [24:0] WD_CYC0 = 25'(`WD_CYC(`WD_T0_US)),
  parameter logic [24:0] WD_CYC1 = 25'(`WD_CYC(`WD_T1_US)),
  parameter logic [24:0] WD_CYC2 = 25'(`WD_CYC(`WD_T2_US)),
  parameter logic [24:0] WD_CYC3 = 25'(`WD_CYC(`WD_T3_US)),
  parameter logic [15:0] CM_MIN_CYC = 16'(`CM_TRIP_HZ / `CM_REF_HZ),
  parameter logic [4:0] RST_CYC = 5'(`CPU_RST_CYC)
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic nv_stored,
  output logic nv_write_en,
  output logic nv_write_data,
  input wire logic clkmon_ref,
  input wire logic irq_n,
  input wire logic reset_btn_n,
  input wire logic stop_instr,
  input wire logic wait_for_interrupt_instr,
  input wire logic cc_stop_disable,
  input wire logic cc_irq_mask,
  output logic cpu_reset,
  output logic [15:0] reset_vector,
  output logic clocks_halted,
  output logic cpu_halted,
  output logic wake_irq,
  output logic irq
);
  supervisor_t st;
  supervisor_t next_st;
  logic [2:0] pins;
  logic ref_s;
  logic irq_n_s;
  logic btn_n_s;
  logic wd_disable;
  logic acc;
  logic cfg_wr;
  logic svc_wr;
  logic svc_done;
  logic svc_bad;
  logic wd_counting;
  logic wd_fire;
  logic cm_active;
  logic ref_edge;
  logic cm_fire;
  logic stop_go;
  logic btn_fire;
  logic reset_event;
  logic irq_unmasked;
  logic [24:0] limit;
  logic [31:0] rd_word;

  if (WD_CYC0 == 25'h0 || WD_CYC1 == 25'h0 || WD_CYC2 == 25'h0 ||
      WD_CYC3 == 25'h0 || CM_MIN_CYC < 16'h2 || RST_CYC == 5'h0)
  begin : g_bad_param
    $error("watchdog counts must be nonzero and monitor count above 1");
  end

  ////////////////////////////////////////////////////////////////////////
  pin_sync3 #(
    .WIDTH(3),
    .RESET_VAL(`SYNC_RESET)
  ) u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({reset_btn_n, irq_n, clkmon_ref}),
    .level(pins)
  );
  assign ref_s = pins[0];
  assign irq_n_s = pins[1];
  assign btn_n_s = pins[2];

  assign cfg_wr = st.dph_wr && st.dph_addr == `A_CONFIG;

  nv_config_cell u_nv (
    .hclk(hclk),
    .hresetn(hresetn),
    .nv_stored(nv_stored),
    .wr_en(cfg_wr),
    .wr_val(hwdata[0]),
    .value(wd_disable),
    .nv_write_en(nv_write_en),
    .nv_write_data(nv_write_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Only whole-word transfers are taken; others complete but do nothing.
  assign acc = hsel && hready && htrans[1] && hsize == 3'h2;
  assign svc_wr = st.dph_wr && st.dph_addr == `A_SERVICE;
  assign svc_done = svc_wr && st.svc == SVC_ARMED &&
                    hwdata[7:0] == `SVC_SECOND;
  assign svc_bad = svc_wr && !svc_done &&
                   hwdata[7:0] != `SVC_FIRST;

  always_comb
  begin
    case (st.tsel)
      2'b00: limit = WD_CYC0;
      2'b01: limit = WD_CYC1;
      2'b10: limit = WD_CYC2;
      default: limit = WD_CYC3;
    endcase
  end

  // The counter freezes while clocks are halted by stop.
  assign wd_counting = !wd_disable && st.pwr != PWR_STOPPED &&
                       st.rst_cnt == 5'h0;
  assign wd_fire = wd_counting && !svc_done &&
                   st.wd_cnt >= limit - 25'h1;
  assign cm_active = st.cm_en || st.cm_force;
  assign ref_edge = ref_s && !st.ref_prev;
  // A stopped hclk cannot be seen by logic clocked on it; this side catches
  // a slowed clock, measured against one reference period, and a stop taken while it is on.
  assign stop_go = stop_instr && st.pwr == PWR_RUN &&
                   !cc_stop_disable;
  assign cm_fire = st.rst_cnt == 5'h0 && cm_active &&
                   ((ref_edge && st.cm_armed && st.cm_cnt < CM_MIN_CYC) ||
                    stop_go);
  assign btn_fire = !btn_n_s;
  assign reset_event = btn_fire || wd_fire || cm_fire;
  assign irq_unmasked = !irq_n_s && !cc_irq_mask;

  always_comb
  begin
    case (haddr[7:0])
      `A_SERVICE: rd_word = {31'h0, st.svc};
      `A_OPTION: rd_word = {28'h0, st.cm_force, st.cm_en, st.tsel};
      `A_CONFIG: rd_word = {31'h0, wd_disable};
      `A_STATUS: rd_word = {29'h0, st.status};
      `A_MASK: rd_word = {29'h0, st.mask};
      `A_COUNT: rd_word = {7'h0, st.wd_cnt};
      `A_VECTOR: rd_word = {16'h0, st.vector};
      default: rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_st = st;
    next_st.wake = 1'b0;
    next_st.dph_wr = acc && hwrite;
    next_st.dph_addr = haddr[7:0];
    if (acc && !hwrite)
    begin
      next_st.rdata = rd_word;
    end
    if (st.win_cnt < `SEL_WINDOW)
    begin
      next_st.win_cnt = st.win_cnt + 7'h1;
    end
    if (st.dph_wr)
    begin
      case (st.dph_addr)
        `A_OPTION:
        begin
          if (st.win_cnt < `SEL_WINDOW)
          begin
            next_st.tsel = hwdata[`OPT_SEL_HI:`OPT_SEL_LO];
          end
          next_st.cm_en = hwdata[`OPT_CM_EN];
          if (hwdata[`OPT_CM_FORCE])
          begin
            next_st.cm_force = 1'b1;
          end
        end
        `A_STATUS: next_st.status = st.status & ~hwdata[2:0];
        `A_MASK: next_st.mask = hwdata[2:0];
        default: next_st.mask = st.mask;
      endcase
    end
    // Watchdog timing and the service sequence.
    if (wd_counting)
    begin
      next_st.wd_cnt = st.wd_cnt + 25'h1;
    end
    else if (wd_disable)
    begin
      next_st.wd_cnt = 25'h0;
    end
    if (svc_wr && hwdata[7:0] == `SVC_FIRST)
    begin
      next_st.svc = SVC_ARMED;
    end
    if (svc_done)
    begin
      next_st.svc = SVC_IDLE;
      next_st.wd_cnt = 25'h0;
    end
    if (svc_bad)
    begin
      next_st.status[`ST_BADSVC] = 1'b1;
    end
    // Clock monitor: cycles per reference period, saturating.
    next_st.ref_prev = ref_s;
    if (st.cm_cnt != 16'hffff)
    begin
      next_st.cm_cnt = st.cm_cnt + 16'h1;
    end
    if (ref_edge)
    begin
      next_st.cm_cnt = 16'h0;
      next_st.cm_armed = cm_active;
    end
    if (!cm_active)
    begin
      next_st.cm_armed = 1'b0;
    end
    // Power states.
    case (st.pwr)
      PWR_RUN:
      begin
        if (stop_go && !cm_active)
        begin
          next_st.pwr = PWR_STOPPED;
        end
        else if (wait_for_interrupt_instr)
        begin
          next_st.pwr = PWR_WAITING;
        end
      end
      PWR_STOPPED, PWR_WAITING:
      begin
        if (irq_unmasked)
        begin
          next_st.pwr = PWR_RUN;
          next_st.wake = 1'b1;
        end
      end
      default: next_st.pwr = PWR_RUN;
    endcase
    // Processor reset; the button is reloaded for as long as it is held.
    if (st.rst_cnt != 5'h0)
    begin
      next_st.rst_cnt = st.rst_cnt - 5'h1;
    end
    if (reset_event && (st.rst_cnt == 5'h0 || btn_fire))
    begin
      next_st.rst_cnt = RST_CYC;
      next_st.pwr = PWR_RUN;
      next_st.wake = 1'b0;
      next_st.svc = SVC_IDLE;
      next_st.wd_cnt = 25'h0;
      next_st.win_cnt = 7'h0;
      next_st.tsel = 2'b00;
      next_st.cm_en = 1'b0;
      next_st.cm_force = 1'b0;
      next_st.cm_armed = 1'b0;
      if (btn_fire)
      begin
        next_st.vector = `VEC_POR;
      end
      else if (wd_fire)
      begin
        next_st.vector = `VEC_WDOG;
        next_st.status[`ST_WDOG] = 1'b1;
      end
      else
      begin
        next_st.vector = `VEC_CLKMON;
        next_st.status[`ST_CLKMON] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '{pwr: PWR_RUN, svc: SVC_IDLE, rst_cnt: RST_CYC,
              vector: `VEC_POR, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign cpu_reset = st.rst_cnt != 5'h0;
  assign reset_vector = st.vector;
  assign clocks_halted = st.pwr == PWR_STOPPED;
  assign cpu_halted = st.pwr != PWR_RUN;
  assign wake_irq = st.wake;
  assign irq = |(st.status & st.mask);

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wd_expiry_a: assert property (
    wd_counting && !svc_done && st.wd_cnt == limit - 25'h1 |=>
      cpu_reset && reset_vector == `VEC_WDOG && st.status[`ST_WDOG])
    else $error("watchdog expiry did not reset with its vector");
  wd_interval_a: assert property (
    st.rst_cnt == 5'h0 && !wd_disable |-> st.wd_cnt < limit)
    else $error("watchdog count passed the selected interval");
  sel_lock_a: assert property (
    st.win_cnt == `SEL_WINDOW && !reset_event |=> $stable(st.tsel))
    else $error("time-out select changed after its window");
  wd_off_a: assert property (
    wd_disable |-> !wd_fire && next_st.wd_cnt == 25'h0)
    else $error("disabled watchdog is still timing");
  nv_write_a: assert property (
    cfg_wr |=> nv_write_en && nv_write_data == $past(hwdata[0]))
    else $error("config write did not reach the nonvolatile store");
  svc_restart_a: assert property (
    svc_done && !btn_fire |=> st.wd_cnt == 25'h0 && st.svc == SVC_IDLE)
    else $error("completed service did not restart timing");
  cm_slow_a: assert property (
    st.rst_cnt == 5'h0 && cm_active && ref_edge && st.cm_armed &&
    st.cm_cnt < CM_MIN_CYC && !btn_fire && !wd_fire |=>
      cpu_reset && reset_vector == `VEC_CLKMON)
    else $error("slow clock did not raise a monitor reset");
  cm_fast_a: assert property (
    cm_fire |-> stop_go || st.cm_cnt < CM_MIN_CYC)
    else $error("monitor reset with an adequate clock");
  cm_force_a: assert property (
    st.cm_force && !reset_event |=> st.cm_force)
    else $error("forced monitor enable dropped before reset");
  stop_nop_a: assert property (
    stop_instr && cc_stop_disable && st.pwr == PWR_RUN |=>
      st.pwr != PWR_STOPPED)
    else $error("stop taken while stop-disable was set");
  stop_reset_a: assert property (
    stop_go && st.rst_cnt == 5'h0 && cm_active |=>
      cpu_reset && !clocks_halted)
    else $error("stop with monitor on did not reset");
  wake_a: assert property (
    cpu_halted && irq_unmasked && !reset_event |=>
      wake_irq && !cpu_halted)
    else $error("unmasked interrupt did not end the low-power state");
  wait_hold_a: assert property (
    st.pwr == PWR_WAITING && irq_n_s && !reset_event |=> cpu_halted)
    else $error("wait ended without interrupt or reset");
  btn_vec_a: assert property (
    btn_fire |=> cpu_reset && reset_vector == `VEC_POR)
    else $error("button reset took the wrong vector");
  bad_svc_a: assert property (
    svc_bad && wd_counting && !wd_fire |=>
      st.wd_cnt == $past(st.wd_cnt) + 25'h1 &&
      st.svc == $past(st.svc))
    else $error("wrong service value changed the sequence");

  svc_cycle_c: cover property (svc_done);
  wd_fire_c: cover property (wd_fire);
  stop_wake_c: cover property (st.pwr == PWR_STOPPED ##1 wake_irq);
  cm_fire_c: cover property (cm_fire && !stop_go);
endmodule

// [watchdog_defines.svh]
// Constants of the watchdog and clock monitor: timing, offsets, fields.
// Assumes a 50 MHz bus clock; included by bare name where needed.
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH
`define CLK_PERIOD_NS 20
`define WD_T0_US 8192
`define WD_T1_US 32768
`define WD_T2_US 131070
`define WD_T3_US 524500
`define WD_CYC(us) ((us) * 1000 / `CLK_PERIOD_NS)
`define SEL_WINDOW 7'h40
`define SVC_FIRST 8'h55
`define SVC_SECOND 8'haa
`define CPU_RST_CYC 16
`define CM_REF_HZ 1000
`define CM_TRIP_HZ 100000
`define A_SERVICE 8'h00
`define A_OPTION 8'h04
`define A_CONFIG 8'h08
`define A_STATUS 8'h0c
`define A_MASK 8'h10
`define A_COUNT 8'h14
`define A_VECTOR 8'h18
`define OPT_SEL_LO 0
`define OPT_SEL_HI 1
`define OPT_CM_EN 2
`define OPT_CM_FORCE 3
`define ST_WDOG 0
`define ST_CLKMON 1
`define ST_BADSVC 2
`define VEC_POR 16'hfffe
`define VEC_WDOG 16'hfff0
`define VEC_CLKMON 16'hfff2
`define SYNC_RESET 3'h6
`endif

// [watchdog_pkg.sv]
// Types of the watchdog and clock monitor.
// Assumes nothing of its surroundings.
package watchdog_pkg;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_STOPPED = 2'b01,
    PWR_WAITING = 2'b10
  } power_t;
  typedef enum logic {
    SVC_IDLE = 1'b0,
    SVC_ARMED = 1'b1
  } svc_t;
  typedef struct packed {
    logic [1:0] tsel;
    logic [6:0] win_cnt;
    logic cm_en;
    logic cm_force;
    logic [2:0] status;
    logic [2:0] mask;
    svc_t svc;
    logic [24:0] wd_cnt;
    power_t pwr;
    logic [4:0] rst_cnt;
    logic [15:0] vector;
    logic [15:0] cm_cnt;
    logic ref_prev;
    logic cm_armed;
    logic wake;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } supervisor_t;
  typedef struct packed {
    logic loaded;
    logic value;
    logic wr_pulse;
  } nv_state_t;
endpackage

// [pin_sync3.sv]
// Three-stage synchroniser for asynchronous pins, one lane per bit.
// Assumes the pins may change at any time relative to hclk.
`timescale 1ns/100ps
module pin_sync3
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;
  logic [WIDTH-1:0] next_held;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync3 needs at least one lane");
  end

  // A change counts only once the second and third stages agree.
  for (genvar gi = 0; gi < WIDTH; gi++) begin : g_lane
    assign next_held[gi] = (st.s2[gi] == st.s3[gi]) ? st.s3[gi] : st.held[gi];
  end

  always_comb
  begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.held = next_held;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level = st.held;
endmodule

// [nv_config_cell.sv]
// Watchdog-disable bit backed by an external nonvolatile store.
// Assumes nv_stored is the stored value, steady on hclk, and that the
// store commits nv_write_data whenever nv_write_en pulses.
`timescale 1ns/100ps
module nv_config_cell
  import watchdog_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic nv_stored,
  input wire logic wr_en,
  input wire logic wr_val,
  output logic value,
  output logic nv_write_en,
  output logic nv_write_data
);
  nv_state_t st;
  nv_state_t next_st;

  // The stored value is caught at the first edge after release; until
  // then the bit reads as set, so the watchdog stays off.
  always_comb
  begin
    next_st = st;
    next_st.loaded = 1'b1;
    next_st.wr_pulse = 1'b0;
    if (!st.loaded)
    begin
      next_st.value = nv_stored;
    end
    if (wr_en)
    begin
      next_st.value = wr_val;
      next_st.wr_pulse = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '{loaded: 1'b0, value: 1'b1, wr_pulse: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign value = st.value;
  assign nv_write_en = st.wr_pulse;
  assign nv_write_data = st.value;
endmodule

// [nv_store_model.sv]
// Model of the nonvolatile store behind the watchdog-disable bit.
// Assumes commits arrive as one-cycle pulses on the bus clock.
`timescale 1ns/100ps
module nv_store_model
(
  input wire logic hclk,
  input wire logic nv_write_en,
  input wire logic nv_write_data,
  output logic nv_stored
);
  // The part leaves the factory with the watchdog turned off.
  initial nv_stored = 1'b1;

  // No reset here: the stored bit must outlive every reset.
  always @(posedge hclk)
  begin
    if (nv_write_en === 1'b1)
      nv_stored <= nv_write_data;
  end
endmodule

// [tb_top.sv]
// Testbench of the watchdog and clock monitor: AHB-Lite master, pins.
// Assumes the design files and the store model are compiled first.
`timescale 1ns/100ps
`include "watchdog_defines.svh"
module tb_top;
  localparam int L0 = 200;
  localparam int L1 = 300;
  localparam int L2 = 400;
  localparam int L3 = 500;
  int lim [4] = '{L0, L1, L2, L3};
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, nv_stored, nv_write_en, nv_write_data;
  logic clkmon_ref = 0, irq_n = 1, reset_btn_n = 1, stop_instr = 0;
  logic wait_for_interrupt_instr = 0, cc_stop_disable = 1;
  logic cc_irq_mask = 1, cpu_reset, clocks_halted, cpu_halted;
  logic wake_irq, irq, rd_dp = 0;
  logic [15:0] reset_vector;
  logic [31:0] exp_q [$];
  int n_fail = 0, cmp_count = 0, cyc = 0, ref_half = 0, t, t_hit, d;
  logic [7:0] bv;

  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;

  watchdog_and_clock_monitor #(.WD_CYC0(25'(L0)), .WD_CYC1(25'(L1)),
    .WD_CYC2(25'(L2)), .WD_CYC3(25'(L3))) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .nv_stored(nv_stored), .nv_write_en(nv_write_en),
    .nv_write_data(nv_write_data), .clkmon_ref(clkmon_ref),
    .irq_n(irq_n), .reset_btn_n(reset_btn_n), .stop_instr(stop_instr),
    .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .cc_stop_disable(cc_stop_disable), .cc_irq_mask(cc_irq_mask),
    .cpu_reset(cpu_reset), .reset_vector(reset_vector),
    .clocks_halted(clocks_halted), .cpu_halted(cpu_halted),
    .wake_irq(wake_irq), .irq(irq));

  nv_store_model nv_u (.hclk(hclk), .nv_write_en(nv_write_en),
    .nv_write_data(nv_write_data), .nv_stored(nv_stored));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read data is judged here, one queued note per completed read.
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout === 1'b1)
      check(hrdata, exp_q.size() ? exp_q.pop_front() : 32'hx);
    if (hreadyout === 1'b1)
      rd_dp <= hsel & htrans[1] & ~hwrite;
  end

  always
  begin
    @(posedge hclk);
    if (ref_half != 0 && cyc % ref_half == 0)
      clkmon_ref <= ~clkmon_ref;
  end

  initial
  begin
    #1500000;
    n_fail++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wait_rdy();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_fail++;
      end_sim();
    end
  endtask

  // Address phase is held until hready, then data is held until hready.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] dat);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dat;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus(1'b1, a, dat);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // Waits a bounded time for cpu_reset (k=0) or wake_irq (k=1).
  task automatic wait_on(input int k, input int n, input bit want);
    bit got;
    got = 0;
    for (int i = 0; i < n && !got; i++)
    begin
      @(posedge hclk);
      #1;
      if ((k == 0 ? cpu_reset : wake_irq) === 1'b1)
      begin
        got = 1;
        t_hit = cyc;
      end
    end
    check({31'h0, got}, {31'h0, want});
    if (want && !got)
      end_sim();
  endtask

  task automatic wait_rel();
    for (int i = 0; i < 100 && cpu_reset !== 1'b0; i++)
      @(posedge hclk);
    #1;
    check({31'h0, cpu_reset}, 32'h0);
  endtask

  task automatic pulse_stop();
    @(posedge hclk);
    stop_instr <= 1'b1;
    @(posedge hclk);
    stop_instr <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hd5f0));
    repeat (20) @(posedge hclk);
    #1;
    check({31'h0, cpu_reset}, 32'h1);
    check({16'h0, reset_vector}, {16'h0, `VEC_POR});
    check({31'h0, hresp}, 32'h0);
    hresetn <= 1'b1;
    wait_rel();
    rd(`A_CONFIG, 32'h1);
    rd(8'h1c, 32'h0);
    wait_on(0, 600, 0);
    wr(`A_CONFIG, 32'h0);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wait_rel();
    rd(`A_CONFIG, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      wr(`A_OPTION, 32'(s));
      repeat (60) @(posedge hclk);
      wr(`A_OPTION, 32'(3 - s));
      rd(`A_OPTION, 32'(s));
      wr(`A_SERVICE, {24'h0, `SVC_FIRST});
      repeat ($urandom_range(1, 20)) @(posedge hclk);
      wr(`A_SERVICE, {24'h0, `SVC_SECOND});
      t = cyc;
      repeat (2)
      begin
        do bv = 8'($urandom_range(0, 255));
        while (bv == `SVC_FIRST || bv == `SVC_SECOND);
        wr(`A_SERVICE, {24'h0, bv});
      end
      wait_on(0, lim[s] + 20, 1);
      d = t_hit - t;
      check(32'(d >= lim[s] - 1 && d <= lim[s] + 4), 32'h1);
      wait_rel();
      rd(`A_VECTOR, {16'h0, `VEC_WDOG});
    end
    wr(`A_CONFIG, 32'h1);
    rd(`A_STATUS, 32'h5);
    wr(`A_STATUS, 32'h7);
    rd(`A_STATUS, 32'h0);
    wr(`A_MASK, 32'h4);
    wr(`A_SERVICE, {24'h0, `SVC_SECOND});
    #1;
    check({31'h0, irq}, 32'h1);
    wr(`A_MASK, 32'h0);
    #1;
    check({31'h0, irq}, 32'h0);
    wr(`A_STATUS, 32'h4);
    rd(`A_STATUS, 32'h0);
    wr(`A_OPTION, 32'h4);
    ref_half = 150;
    wait_on(0, 1000, 0);
    ref_half = 20;
    wait_on(0, 400, 1);
    wait_rel();
    rd(`A_VECTOR, {16'h0, `VEC_CLKMON});
    wr(`A_OPTION, 32'hc);
    wr(`A_OPTION, 32'h0);
    wait_on(0, 400, 1);
    wait_rel();
    wait_on(0, 400, 0);
    ref_half = 0;
    wr(`A_OPTION, 32'h4);
    cc_stop_disable <= 1'b0;
    pulse_stop();
    wait_on(0, 10, 1);
    check({31'h0, clocks_halted}, 32'h0);
    wait_rel();
    cc_stop_disable <= 1'b1;
    pulse_stop();
    repeat (2) @(posedge hclk);
    #1;
    check({31'h0, clocks_halted}, 32'h0);
    cc_stop_disable <= 1'b0;
    pulse_stop();
    repeat (2) @(posedge hclk);
    #1;
    check({31'h0, clocks_halted}, 32'h1);
    irq_n <= 1'b0;
    wait_on(1, 10, 0);
    cc_irq_mask <= 1'b0;
    wait_on(1, 10, 1);
    check({31'h0, clocks_halted}, 32'h0);
    irq_n <= 1'b1;
    cc_irq_mask <= 1'b1;
    repeat (8) @(posedge hclk);
    wait_for_interrupt_instr <= 1'b1;
    @(posedge hclk);
    wait_for_interrupt_instr <= 1'b0;
    irq_n <= 1'b0;
    wait_on(1, 10, 0);
    check({31'h0, cpu_halted}, 32'h1);
    reset_btn_n <= 1'b0;
    wait_on(0, 10, 1);
    reset_btn_n <= 1'b1;
    wait_rel();
    check({31'h0, cpu_halted}, 32'h0);
    rd(`A_VECTOR, {16'h0, `VEC_POR});
    wait_for_interrupt_instr <= 1'b1;
    @(posedge hclk);
    wait_for_interrupt_instr <= 1'b0;
    cc_irq_mask <= 1'b0;
    wait_on(1, 10, 1);
    check({31'h0, cpu_halted}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    repeat (4) @(posedge hclk);
    end_sim();
  end
endmodule
